// file: design/add_and_bit_op_execute.sv
// Purpose: Executes add-to-file and the three single-bit file instructions.
// Assumes: Software writes one 14-bit instruction word per write to the instruction register.
// Notes: Any other instruction pattern executes as a no-operation.
`timescale 1ns/1ps
`default_nettype none

module add_and_bit_op_execute (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////////

	function automatic add_bit_pkg::op_type decode_op(input logic [13:0] word);
		if (word[13:8] == add_bit_pkg::ADD_PATTERN) begin
			return add_bit_pkg::OP_ADD;
		end else if (word[13:10] == add_bit_pkg::CLEAR_PATTERN) begin
			return add_bit_pkg::OP_CLEAR;
		end else if (word[13:10] == add_bit_pkg::SET_PATTERN) begin
			return add_bit_pkg::OP_SET;
		end else if (word[13:10] == add_bit_pkg::TEST_PATTERN) begin
			return add_bit_pkg::OP_TEST;
		end
		return add_bit_pkg::OP_NONE;
	endfunction

	// File registers fill the second eighth of the map, one aligned word each.
	function automatic logic is_file(input logic [11:0] addr);
		return (addr[11:9] == add_bit_pkg::FILE_BASE_TOP) && (addr[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Release is synchronised so that no state leaves reset close to a clock edge.
	logic rst_meta;
	logic rst_s;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_s <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	localparam add_bit_pkg::state_type STATE_RESET = '{
		work: add_bit_pkg::WORK_RESET,
		files: {128{add_bit_pkg::FILE_RESET}},
		bresp: add_bit_pkg::RESP_OKAY,
		rresp: add_bit_pkg::RESP_OKAY,
		default: '0
	};

	add_bit_pkg::state_type st;
	add_bit_pkg::state_type next_st;
	add_bit_pkg::op_type opsel;
	logic exec;
	logic run;
	logic [6:0] fa;
	logic [2:0] bsel;
	logic [7:0] fval;
	logic bitval;
	logic [8:0] add_sum;
	logic [4:0] add_low;
	logic wr_act;

	// The decode follows whatever word was written last; only exec gives it meaning.
	assign opsel = decode_op(st.wdata[13:0]);
	assign fa = st.wdata[6:0];
	assign bsel = st.wdata[9:7];
	assign fval = st.files[fa];
	assign bitval = fval[bsel];
	assign add_sum = {1'b0, st.work} + {1'b0, fval};
	assign add_low = {1'b0, st.work[3:0]} + {1'b0, fval[3:0]};
	assign run = exec && !st.skip_pend;
	assign wr_act = st.aw_have && st.w_have && !st.bvalid;

	always_comb begin
		next_st = st;
		exec = 1'b0;
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_have = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_have = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Address and data may arrive in either order; the write acts once both are held.
		if (wr_act) begin
			next_st.aw_have = 1'b0;
			next_st.w_have = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = add_bit_pkg::RESP_OKAY;
			if (st.awaddr == add_bit_pkg::INSTR_OFS) begin
				exec = 1'b1;
			end else if (st.awaddr == add_bit_pkg::WORK_OFS) begin
				if (st.wstrb[0]) begin
					next_st.work = st.wdata[7:0];
				end
			end else if (st.awaddr == add_bit_pkg::STATUS_OFS) begin
				if (st.wstrb[0]) begin
					next_st.carry = st.wdata[add_bit_pkg::CARRY_POS];
					next_st.dcarry = st.wdata[add_bit_pkg::DCARRY_POS];
					next_st.zero = st.wdata[add_bit_pkg::ZERO_POS];
				end
			end else if (is_file(st.awaddr)) begin
				if (st.wstrb[0]) begin
					next_st.files[st.awaddr[8:2]] = st.wdata[7:0];
				end
			end else begin
				next_st.bresp = add_bit_pkg::RESP_SLVERR;
			end
		end
		// A pending skip swallows the next word and spends one cycle as a no-operation.
		if (exec && st.skip_pend) begin
			next_st.skip_pend = 1'b0;
			next_st.cycles = st.cycles + 32'h1;
		end
		if (run) begin
			next_st.cycles = st.cycles + 32'h1;
			case (opsel)
				add_bit_pkg::OP_ADD: begin
					if (st.wdata[7]) begin
						next_st.files[fa] = add_sum[7:0];
					end else begin
						next_st.work = add_sum[7:0];
					end
					next_st.carry = add_sum[8];
					next_st.dcarry = add_low[4];
					next_st.zero = (add_sum[7:0] == 8'h00);
				end
				add_bit_pkg::OP_CLEAR: begin
					next_st.files[fa][bsel] = 1'b0;
				end
				add_bit_pkg::OP_SET: begin
					next_st.files[fa][bsel] = 1'b1;
				end
				add_bit_pkg::OP_TEST: begin
					next_st.skip_pend = !bitval;
				end
				default: begin
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = add_bit_pkg::RESP_OKAY;
			next_st.rdata = 32'h0;
			if (s_axi_araddr == add_bit_pkg::INSTR_OFS) begin
				next_st.rdata = {18'h0, st.wdata[13:0]};
			end else if (s_axi_araddr == add_bit_pkg::WORK_OFS) begin
				next_st.rdata = {24'h0, st.work};
			end else if (s_axi_araddr == add_bit_pkg::STATUS_OFS) begin
				next_st.rdata = {28'h0, st.skip_pend, st.zero, st.dcarry, st.carry};
			end else if (s_axi_araddr == add_bit_pkg::CYCLES_OFS) begin
				next_st.rdata = st.cycles;
			end else if (is_file(s_axi_araddr)) begin
				next_st.rdata = {24'h0, st.files[s_axi_araddr[8:2]]};
			end else begin
				next_st.rresp = add_bit_pkg::RESP_SLVERR;
			end
		end
		// Ready drops while a response waits, so one write and one read are in flight at most.
		next_st.awready = !next_st.aw_have && !next_st.bvalid;
		next_st.wready = !next_st.w_have && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge ref_clk or negedge rst_s) begin
		if (!rst_s) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	////////////////////////////////////////////////////////////////////////////////

	// Execution checks work from the decode; only a_add_decode matches the raw opcode bits instead.
	a_add_decode: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && st.wdata[13:8] == 6'h07 && !st.wdata[7])
		|=> st.work == $past(8'(st.work + st.files[st.wdata[6:0]])))
		else $error("add pattern did not add work and file");
	a_add_to_work: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_ADD && !st.wdata[7])
		|=> (st.work == $past(add_sum[7:0])) && $stable(st.files))
		else $error("add with destination 0 did not land in work");
	a_add_to_file: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_ADD && st.wdata[7])
		|=> (st.files[$past(fa)] == $past(add_sum[7:0])) && $stable(st.work))
		else $error("add with destination 1 did not land in file");
	a_add_flags: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_ADD)
		|=> st.carry == $past(add_sum[8]) && st.dcarry == $past(add_low[4])
		&& st.zero == ($past(add_sum[7:0]) == 8'h00))
		else $error("add flags wrong");
	a_clear_bit: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_CLEAR)
		|=> !st.files[$past(fa)][$past(bsel)] && $stable({st.carry, st.dcarry, st.zero}))
		else $error("bit clear failed or touched flags");
	a_set_bit: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_SET)
		|=> st.files[$past(fa)][$past(bsel)] && $stable({st.carry, st.dcarry, st.zero}))
		else $error("bit set failed or touched flags");
	a_test_skip: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_TEST)
		|=> (st.skip_pend == !$past(bitval)) && $stable({st.carry, st.dcarry, st.zero}))
		else $error("bit test skip decision wrong");
	a_skip_discard: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(exec && st.skip_pend)
		|=> !st.skip_pend && $stable(st.work) && $stable(st.files)
		&& st.cycles == $past(st.cycles) + 32'h1)
		else $error("skipped word was not discarded as one cycle");
	a_clear_one_bit: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_CLEAR)
		|=> st.files[$past(fa)] == ($past(fval) & ~(8'h01 << $past(bsel))))
		else $error("bit clear touched other bits of the file");
	a_set_one_bit: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_SET)
		|=> st.files[$past(fa)] == ($past(fval) | (8'h01 << $past(bsel))))
		else $error("bit set touched other bits of the file");
	a_test_no_write: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_TEST)
		|=> $stable(st.work) && $stable(st.files))
		else $error("bit test wrote a register");
	a_skip_only_test: assert property (@(posedge ref_clk) disable iff (!rst_s)
		$rose(st.skip_pend) |-> $past(run && opsel == add_bit_pkg::OP_TEST))
		else $error("skip raised without a bit test");
	a_flags_held: assert property (@(posedge ref_clk) disable iff (!rst_s)
		$changed({st.carry, st.dcarry, st.zero})
		|-> $past(run && opsel == add_bit_pkg::OP_ADD)
		|| $past(wr_act && st.awaddr == add_bit_pkg::STATUS_OFS))
		else $error("status flags moved without an add or a status write");
	a_skip_flags: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(exec && st.skip_pend) |=> $stable({st.carry, st.dcarry, st.zero}))
		else $error("discarded word changed the flags");
	a_run_count: assert property (@(posedge ref_clk) disable iff (!rst_s)
		run |=> st.cycles == $past(st.cycles) + 32'h1)
		else $error("executed word did not count one cycle");
	a_other_nop: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(run && opsel == add_bit_pkg::OP_NONE)
		|=> $stable(st.work) && $stable(st.files) && !st.skip_pend
		&& $stable({st.carry, st.dcarry, st.zero}))
		else $error("undecoded word changed state");

	// Register bus checks; the byte strobe guards every register but the instruction.
	a_write_answer: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(st.aw_have && st.w_have && !st.bvalid) |=> st.bvalid)
		else $error("write response missing");
	a_work_strobe: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(wr_act && st.awaddr == add_bit_pkg::WORK_OFS && !st.wstrb[0]) |=> $stable(st.work))
		else $error("work register changed without its byte strobe");
	a_status_write: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(wr_act && st.awaddr == add_bit_pkg::STATUS_OFS && st.wstrb[0])
		|=> {st.zero, st.dcarry, st.carry} == $past(st.wdata[2:0]))
		else $error("status write did not land in the flags");
	a_write_clear: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(st.bvalid && s_axi_bready) |=> !st.bvalid)
		else $error("write response stayed after it was taken");
	a_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(s_axi_arvalid && st.arready) |=> st.rvalid)
		else $error("read response missing");
	a_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_s)
		(st.rvalid && s_axi_rready) |=> !st.rvalid)
		else $error("read response stayed after it was taken");

endmodule // add_and_bit_op_execute

`default_nettype wire

// file: design/add_bit_pkg.sv
// Purpose: Constants and types for the add and bit-operation execute block.
// Assumes: Registers sit on a 32-bit AXI4-Lite slave with a 12-bit byte address.
// Notes: Status flags sit in the low bits of the status register.
//
// Behaviour
// - Decode 000111 prefix as add_w_to_file.
// - Destination bit picks working register or file.
// - Decode 0100 prefix, clear selected file bit.
// - Decode 0101 prefix, set selected file bit.
// - Decode 0110 prefix, skip when bit zero.
// - Skipped instruction becomes a no-operation cycle.
package add_bit_pkg;

	localparam logic [11:0] INSTR_OFS = 12'h000;
	localparam logic [11:0] WORK_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [11:0] CYCLES_OFS = 12'h00c;
	localparam logic [2:0] FILE_BASE_TOP = 3'h1;
	localparam int CARRY_POS = 0;
	localparam int DCARRY_POS = 1;
	localparam int ZERO_POS = 2;
	localparam int SKIP_POS = 3;
	localparam logic [5:0] ADD_PATTERN = 6'h07;
	localparam logic [3:0] CLEAR_PATTERN = 4'h4;
	localparam logic [3:0] SET_PATTERN = 4'h5;
	localparam logic [3:0] TEST_PATTERN = 4'h6;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [7:0] FILE_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_CLEAR,
		OP_SET,
		OP_TEST
	} op_type;

	typedef struct packed {
		logic [7:0] work;
		logic carry;
		logic dcarry;
		logic zero;
		logic skip_pend;
		logic [31:0] cycles;
		logic [127:0][7:0] files;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

endpackage

// file: verification/testbench.sv
// Purpose: Self-checking bench for the add and bit-operation execute block.
// Assumes: Register map and AXI4-Lite timing as handed over with the design.
// Notes: Rows run in order; each one builds on the file state left by those before it.
`timescale 1ns/1ps
`default_nettype none

module testbench;

typedef struct packed {
	logic w;
	logic [11:0] a;
	logic [31:0] d;
	logic [3:0] s;
	logic [1:0] r;
} row_type;

localparam logic [1:0] OK = add_bit_pkg::RESP_OKAY;
localparam logic [1:0] ERR = add_bit_pkg::RESP_SLVERR;
localparam logic W = 1'h1;
localparam logic R = 1'h0;

logic ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready;
logic [11:0] awaddr, araddr;
logic [31:0] wdata, rdata;
logic [3:0] wstrb;
logic [1:0] bresp, rresp;
int miscompares = 0;
int n_tests = 0;

// Writes set up operands first, then the instruction word, then reads check the outcome.
row_type rows [47] = '{
	'{W, 12'h004, 32'h17, 4'hf, OK},
	'{W, 12'h214, 32'hc2, 4'hf, OK},
	'{W, 12'h000, 32'h0705, 4'hf, OK},
	'{R, 12'h004, 32'hd9, 4'hf, OK},
	'{R, 12'h214, 32'hc2, 4'hf, OK},
	'{R, 12'h008, 32'h0, 4'hf, OK},
	'{W, 12'h004, 32'hff, 4'hf, OK},
	'{W, 12'h218, 32'h01, 4'hf, OK},
	'{W, 12'h000, 32'h0786, 4'hf, OK},
	'{R, 12'h218, 32'h00, 4'hf, OK},
	'{R, 12'h004, 32'hff, 4'hf, OK},
	'{R, 12'h008, 32'h7, 4'hf, OK},
	'{W, 12'h21c, 32'hc7, 4'hf, OK},
	'{W, 12'h000, 32'h1387, 4'hf, OK},
	'{R, 12'h21c, 32'h47, 4'hf, OK},
	'{R, 12'h008, 32'h7, 4'hf, OK},
	'{W, 12'h220, 32'h0a, 4'hf, OK},
	'{W, 12'h000, 32'h1788, 4'hf, OK},
	'{R, 12'h220, 32'h8a, 4'hf, OK},
	'{W, 12'h000, 32'h147f, 4'hf, OK},
	'{R, 12'h3fc, 32'h01, 4'hf, OK},
	'{R, 12'h008, 32'h7, 4'hf, OK},
	'{W, 12'h000, 32'h1989, 4'hf, OK},
	'{R, 12'h008, 32'hf, 4'hf, OK},
	'{W, 12'h000, 32'h1409, 4'hf, OK},
	'{R, 12'h224, 32'h00, 4'hf, OK},
	'{R, 12'h008, 32'h7, 4'hf, OK},
	'{W, 12'h000, 32'h1b88, 4'hf, OK},
	'{R, 12'h008, 32'h7, 4'hf, OK},
	'{W, 12'h000, 32'h1489, 4'hf, OK},
	'{R, 12'h224, 32'h02, 4'hf, OK},
	'{W, 12'h004, 32'h08, 4'hf, OK},
	'{W, 12'h228, 32'h08, 4'hf, OK},
	'{W, 12'h000, 32'h070a, 4'hf, OK},
	'{R, 12'h004, 32'h10, 4'hf, OK},
	'{R, 12'h008, 32'h2, 4'hf, OK},
	'{W, 12'h000, 32'h3fff, 4'hf, OK},
	'{R, 12'h000, 32'h3fff, 4'hf, OK},
	'{R, 12'h00c, 32'hb, 4'hf, OK},
	'{W, 12'h008, 32'h0d, 4'hf, OK},
	'{R, 12'h008, 32'h5, 4'hf, OK},
	'{W, 12'h215, 32'h0, 4'hf, ERR},
	'{R, 12'h214, 32'hc2, 4'hf, OK},
	'{W, 12'h004, 32'h55, 4'h0, OK},
	'{R, 12'h004, 32'h10, 4'hf, OK},
	'{W, 12'h010, 32'h0, 4'hf, ERR},
	'{R, 12'h010, 32'h0, 4'hf, ERR}
};

add_and_bit_op_execute uut (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.s_axi_awaddr(awaddr),
	.s_axi_awvalid(awvalid),
	.s_axi_awready(awready),
	.s_axi_wdata(wdata),
	.s_axi_wstrb(wstrb),
	.s_axi_wvalid(wvalid),
	.s_axi_wready(wready),
	.s_axi_bresp(bresp),
	.s_axi_bvalid(bvalid),
	.s_axi_bready(bready),
	.s_axi_araddr(araddr),
	.s_axi_arvalid(arvalid),
	.s_axi_arready(arready),
	.s_axi_rdata(rdata),
	.s_axi_rresp(rresp),
	.s_axi_rvalid(rvalid),
	.s_axi_rready(rready)
);

////////////////////////////////////////////////////////////////////////////////

initial begin
	ref_clk = 1'h0;
	forever #2.5 ref_clk = ~ref_clk;
end

task automatic wrap_up();
	if (miscompares == 0 && n_tests > 0) begin
		$display("Finished cleanly");
	end else begin
		$display("Finished with errors");
	end
	$finish;
endtask

task automatic compare(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		miscompares++;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
	end
endtask

// A response that never comes ends the run, since later rows depend on it.
task automatic give_up(input logic seen);
	if (seen !== 1'h1) begin
		miscompares++;
		wrap_up();
	end
endtask

task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
	input logic [1:0] r);
	int n;
	n = 0;
	awaddr <= a;
	wdata <= d;
	wstrb <= s;
	awvalid <= 1'h1;
	wvalid <= 1'h1;
	do begin
		@(posedge ref_clk);
		n++;
		if (awready && awvalid) awvalid <= 1'h0;
		if (wready && wvalid) wvalid <= 1'h0;
	end while (bvalid !== 1'h1 && n < 64);
	give_up(bvalid);
	compare({30'h0, bresp}, {30'h0, r});
endtask

task automatic read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
	int n;
	n = 0;
	araddr <= a;
	arvalid <= 1'h1;
	do begin
		@(posedge ref_clk);
		n++;
		if (arready && arvalid) arvalid <= 1'h0;
	end while (rvalid !== 1'h1 && n < 64);
	give_up(rvalid);
	compare(rdata, d);
	compare({30'h0, rresp}, {30'h0, r});
endtask

////////////////////////////////////////////////////////////////////////////////

initial begin
	{nrst, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
	bready = 1'h1;
	rready = 1'h1;
	repeat (16) @(posedge ref_clk);
	nrst <= 1'h1;
	repeat (8) @(posedge ref_clk);
	foreach (rows[i]) begin
		if (rows[i].w) write(rows[i].a, rows[i].d, rows[i].s, rows[i].r);
		else read(rows[i].a, rows[i].d, rows[i].r);
	end
	// A second reset mid-run must bring working, status, count and files back to zero.
	nrst <= 1'h0;
	repeat (2) @(posedge ref_clk);
	compare({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h0);
	nrst <= 1'h1;
	repeat (8) @(posedge ref_clk);
	compare({29'h0, awready, wready, arready}, 32'h7);
	read(12'h004, 32'h0, OK);
	read(12'h008, 32'h0, OK);
	read(12'h00c, 32'h0, OK);
	read(12'h224, 32'h0, OK);
	wrap_up();
end

endmodule // testbench
`default_nettype wire
